// file: hdl/imab_top.sv
// APB-facing indirect access buffer to the switch's internal memory.
// Assumes a single pclk domain and a well-behaved APB master.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module imab_top
    import imab_pkg::*;
#(
    parameter int data_width = 16
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt
    output logic irq
);
    initial begin
        if (data_width != 16)
            $error("imab_top: only 16-bit words are supported");
    end

    logic [15:0] address_buffer;
    logic [15:0] data_write_holding;
    logic [15:0] data_read_holding;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic op_write;
    logic mem_req;
    logic mem_req_busy;
    logic mem_ack;
    logic [15:0] mem_rdata;

    // Bus decode
    wire apb_write = psel && penable && pwrite;
    wire apb_read_setup = psel && !penable && !pwrite;
    wire hit_addr_buf = paddr == addr_address_buffer;
    wire hit_wr_hold = paddr == addr_data_write_holding;
    wire hit_rd_hold = paddr == addr_data_read_holding;
    wire hit_ists = paddr == addr_irq_status;
    wire hit_imsk = paddr == addr_irq_mask;
    wire hit_any = hit_addr_buf || hit_wr_hold || hit_rd_hold || hit_ists ||
        hit_imsk;
    wire wr_addr_buf = apb_write && hit_addr_buf;

    // Field views of the address buffer
    wire done_flag = address_buffer[done_pos];
    wire read_req = address_buffer[read_req_pos];
    wire write_req = address_buffer[write_req_pos];
    wire [6:0] channel_pointer = address_buffer[chan_lsb +: chan_width];
    wire [4:0] stream_pointer = address_buffer[stream_lsb +: stream_width];
    // Stream and channel in binary form the memory word address
    wire [11:0] mem_addr = {stream_pointer, channel_pointer};

    // Software's proposed request bits
    wire new_read_req = wr_addr_buf ? pwdata[read_req_pos] : read_req;
    wire new_write_req = wr_addr_buf ? pwdata[write_req_pos] : write_req;
    wire read_rise = new_read_req && !read_req;
    wire write_rise = new_write_req && !write_req;
    wire req_fall = (read_req && !new_read_req) ||
        (write_req && !new_write_req);
    // Only one access at a time; a second rise during a busy access is dropped
    wire start = (read_rise || write_rise) && !mem_req_busy;

    // Next address buffer value; completion wins over software writes
    logic [15:0] next_address_buffer;
    always_comb begin
        next_address_buffer = address_buffer;
        if (wr_addr_buf) begin
            next_address_buffer[11:0] = pwdata[11:0];
            next_address_buffer[read_req_pos] = pwdata[read_req_pos];
            next_address_buffer[write_req_pos] = pwdata[write_req_pos];
        end
        next_address_buffer[15] = 1'b0;
        next_address_buffer[done_pos] = done_flag;
        if (req_fall)
            next_address_buffer[done_pos] = 1'b0;
        if (mem_ack) begin
            next_address_buffer[done_pos] = 1'b1;
            next_address_buffer[read_req_pos] = 1'b0;
            next_address_buffer[write_req_pos] = 1'b0;
        end
    end

    // Address buffer register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            address_buffer <= address_buffer_reset;
        else
            address_buffer <= next_address_buffer;
    end

    // Write holding register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            data_write_holding <= data_write_holding_reset;
        else if (apb_write && hit_wr_hold)
            data_write_holding <= pwdata[15:0];
    end

    // Access tracking; pulse a single memory request per transfer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_req <= 1'b0;
            mem_req_busy <= 1'b0;
            op_write <= 1'b0;
        end else begin
            mem_req <= start;
            if (start) begin
                mem_req_busy <= 1'b1;
                op_write <= !read_rise; // Read wins if both rise together
            end else if (mem_ack) begin
                mem_req_busy <= 1'b0;
            end
        end
    end

    // Read holding keeps its word until the next read completes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            data_read_holding <= data_read_holding_reset;
        else if (mem_ack && !op_write)
            data_read_holding <= mem_rdata;
    end

    // Sticky interrupt flags; a new event beats a same-cycle clear
    wire [1:0] irq_event = {mem_ack && op_write, mem_ack && !op_write};
    wire [1:0] irq_clear = (apb_write && hit_ists) ? pwdata[1:0] : 2'b00;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= irq_reset;
            irq_mask <= irq_reset;
            irq <= 1'b0;
        end else begin
            irq_status <= (irq_status & ~irq_clear) | irq_event;
            if (apb_write && hit_imsk)
                irq_mask <= pwdata[1:0];
            irq <= |(((irq_status & ~irq_clear) | irq_event) & irq_mask);
        end
    end

    // Read mux
    logic [31:0] read_mux;
    always_comb begin
        if (hit_addr_buf)
            read_mux = {16'h0000, address_buffer};
        else if (hit_wr_hold)
            read_mux = {16'h0000, data_write_holding};
        else if (hit_rd_hold)
            read_mux = {16'h0000, data_read_holding};
        else if (hit_ists)
            read_mux = {30'h0000_0000, irq_status};
        else if (hit_imsk)
            read_mux = {30'h0000_0000, irq_mask};
        else
            read_mux = 32'h0000_0000;
    end

    // APB answer: no wait state, data registered in setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !hit_any;
            if (apb_read_setup)
                prdata <= read_mux;
        end
    end

    imab_memory #(
        .addr_width(12),
        .data_width(16),
        .latency(mem_latency)
    ) u_memory (
        .pclk(pclk),
        .presetn(presetn),
        .req(mem_req),
        .we(op_write),
        .addr(mem_addr),
        .wdata(data_write_holding),
        .ack(mem_ack),
        .rdata(mem_rdata)
    );
endmodule
`default_nettype wire

// file: hdl/imab_pkg.sv
// Constants for the indirect memory access buffer block.
// Assumes a 32-bit APB slave with word-aligned registers, pclk at 100 MHz.
// Overview of operation
// - Done flag is read only; software writes to its position are ignored.
// - Done flag rises once a word has moved between memory and holding register.
// - Done flag clears when software writes a set read or write request bit to zero, unless a transfer completes in that cycle.
// - Rising read request starts copying the addressed memory word into read holding.
// - Rising write request starts copying write holding into the addressed memory word, unless read request rises in the same cycle.
// - When done flag rises, hardware returns both request bits to zero.
// - Seven-bit channel pointer selects the memory location instead of address lines.
// - Channel pointer is a binary channel number for the accessed memory subsection.
// - Five-bit stream pointer names the stream in binary, like the control stream select.
package imab_pkg;
    // Printed offsets are indices; byte address is four times the index
    localparam logic [7:0] idx_address_buffer = 8'h0c;
    localparam logic [7:0] idx_data_write_holding = 8'h0d;
    localparam logic [7:0] idx_data_read_holding = 8'h0e;
    localparam logic [7:0] idx_irq_status = 8'h10;
    localparam logic [7:0] idx_irq_mask = 8'h11;
    localparam logic [11:0] addr_address_buffer = {2'b00, idx_address_buffer, 2'b00};
    localparam logic [11:0] addr_data_write_holding =
        {2'b00, idx_data_write_holding, 2'b00};
    localparam logic [11:0] addr_data_read_holding =
        {2'b00, idx_data_read_holding, 2'b00};
    localparam logic [11:0] addr_irq_status = {2'b00, idx_irq_status, 2'b00};
    localparam logic [11:0] addr_irq_mask = {2'b00, idx_irq_mask, 2'b00};
    // Address buffer fields
    localparam int done_pos = 14;
    localparam int read_req_pos = 13;
    localparam int write_req_pos = 12;
    localparam int chan_lsb = 5;
    localparam int chan_width = 7;
    localparam int stream_lsb = 0;
    localparam int stream_width = 5;
    localparam logic [15:0] address_buffer_reset = 16'h0000;
    localparam logic [15:0] data_write_holding_reset = 16'h0000;
    localparam logic [15:0] data_read_holding_reset = 16'h0000;
    // Interrupt status bits
    localparam int irq_read_done = 0;
    localparam int irq_write_done = 1;
    localparam logic [1:0] irq_reset = 2'h0;
    // Memory access latency in pclk cycles
    localparam int mem_latency = 2;
endpackage

// file: hdl/imab_memory.sv
// Internal memory array addressed by stream and channel.
// Assumes one request pulse at a time; answers after a fixed latency.
`timescale 1ns/1ns
`default_nettype none
module imab_memory
    import imab_pkg::*;
#(
    parameter int addr_width = 12,
    parameter int data_width = 16,
    parameter int latency = mem_latency
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Request
    input wire logic req,
    input wire logic we,
    input wire logic [addr_width-1:0] addr,
    input wire logic [data_width-1:0] wdata,
    // Answer
    output logic ack,
    output logic [data_width-1:0] rdata
);
    initial begin
        if (latency < 1 || latency > 15)
            $error("imab_memory: latency out of range");
    end

    logic [data_width-1:0] mem [0:(1<<addr_width)-1];
    logic [3:0] wait_count;
    logic busy;

    // Storage; no reset since real memories have none
    always_ff @(posedge pclk) begin
        if (req && we)
            mem[addr] <= wdata;
        if (req && !we)
            rdata <= mem[addr];
    end

    // Latency counter models the slower internal memory port
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy <= 1'b0;
            wait_count <= 4'h0;
            ack <= 1'b0;
        end else begin
            ack <= 1'b0;
            if (req) begin
                busy <= 1'b1;
                wait_count <= 4'(latency - 1);
            end else if (busy && wait_count == 4'h0) begin
                busy <= 1'b0;
                ack <= 1'b1;
            end else if (busy) begin
                wait_count <= wait_count - 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// file: test/imab_asserts.sv
// Checker for the indirect access buffer, watching the top ports only.
// Assumes one pclk domain and an APB master that waits on pready.
`timescale 1ns/1ns
`default_nettype none
module imab_asserts
    import imab_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Interrupt
    input wire logic irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Decode of the five mapped words
    wire logic mapped;
    assign mapped = paddr inside {addr_address_buffer,
        addr_data_write_holding, addr_data_read_holding,
        addr_irq_status, addr_irq_mask};

    property p_ready_one;
        psel && !penable |=> pready;
    endproperty
    a_ready_one: assert property (p_ready_one) else $error("late pready");
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("long pready");
    property p_ready_access;
        pready |-> psel && penable;
    endproperty
    a_ready_access: assert property (p_ready_access)
        else $error("pready outside access");
    property p_err_unmapped;
        pready |-> (pslverr == !mapped);
    endproperty
    a_err_unmapped: assert property (p_err_unmapped)
        else $error("pslverr wrong");
    property p_err_zero;
        pready && pslverr && !pwrite |-> prdata == 32'h0000_0000;
    endproperty
    a_err_zero: assert property (p_err_zero) else $error("error data");
    property p_addr_buf_reserved;
        pready && !pwrite && paddr == addr_address_buffer
            |-> prdata[31:15] == 17'h0;
    endproperty
    a_addr_buf_reserved: assert property (p_addr_buf_reserved)
        else $error("reserved bits set");
    property p_quiet_after_reset;
        $rose(presetn) |-> !pready && !irq;
    endproperty
    a_quiet_after_reset: assert property (p_quiet_after_reset)
        else $error("busy after reset");
    property p_mask_quiet;
        pready && pwrite && paddr == addr_irq_mask && pwdata[1:0] == 2'b00
            |-> ##2 !irq [*3];
    endproperty
    a_mask_quiet: assert property (p_mask_quiet) else $error("masked irq");
endmodule
bind imab_top imab_asserts i_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq));
`default_nettype wire

// file: test/imab_host.sv
// Host processor model: an APB master doing one transfer per call.
// Assumes the slave raises pready within the bench timeout.
`timescale 1ns/1ns
`default_nettype none
module imab_host (
    // Clock
    input wire logic pclk,
    // Answer
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Request
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata
);
    // Idle bus at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
    end

    // Setup, access held until pready, then release with stale data flipped
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
             output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask
endmodule
`default_nettype wire

// file: test/tb_top.sv
// Self-checking bench for the indirect memory access buffer.
// Assumes the host model drives APB and the checker is bound in.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import imab_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    wire logic psel, penable, pwrite, pready, pslverr, irq;
    wire logic [11:0] paddr;
    wire logic [31:0] pwdata, prdata;
    int error_cnt = 0;
    int samples_checked = 0;
    int cyc = 0;
    logic [31:0] rv;
    logic er;

    imab_host i_host (.pclk(pclk), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    imab_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq));

    // Clock and hang guard
    always #5 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            summarize();
        end
    end

    task summarize();
        $display("checked %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        i_host.apb(1'b1, a, d, rv, er);
    endtask

    task rchk(input logic [11:0] a, input logic [31:0] exp);
        i_host.apb(1'b0, a, 32'h0000_0000, rv, er);
        chk(rv, exp);
    endtask

    // Raise one request, poll for done, expect requests cleared
    task xfer(input logic [11:0] p, input logic [1:0] rq);
        int n;
        n = 0;
        wr(addr_address_buffer, {18'h0, rq, p});
        rv = 32'h0000_0000;
        // Done stays set from the last transfer; also wait for requests to drop
        while ((rv[14] !== 1'b1 || rv[13:12] !== 2'b00) && n < 20) begin
            i_host.apb(1'b0, addr_address_buffer, 32'h0000_0000, rv, er);
            n++;
        end
        chk(rv, {17'h0, 3'b100, p});
    endtask

    // Main sequence; bit 12 writes memory, bit 13 reads it
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rchk(addr_address_buffer, 32'h0000_0000);
        rchk(addr_data_write_holding, 32'h0000_0000);
        rchk(addr_data_read_holding, 32'h0000_0000);
        wr(addr_address_buffer, 32'h0000_c553);
        rchk(addr_address_buffer, 32'h0000_0553);
        wr(addr_data_write_holding, 32'h0000_beef);
        rchk(addr_data_write_holding, 32'h0000_beef);
        xfer(12'h553, 2'b01);
        wr(addr_data_write_holding, 32'h0000_1234);
        xfer(12'h544, 2'b01);
        xfer(12'h544, 2'b10);
        rchk(addr_data_read_holding, 32'h0000_1234);
        wr(addr_data_write_holding, 32'h0000_5a5a);
        xfer(12'h573, 2'b01);
        rchk(addr_data_read_holding, 32'h0000_1234);
        xfer(12'h553, 2'b10);
        rchk(addr_data_read_holding, 32'h0000_beef);
        rchk(addr_irq_status, 32'h0000_0003);
        chk({31'h0, irq}, 32'h0000_0000);
        wr(addr_irq_mask, 32'h0000_0003);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0000_0001);
        wr(addr_irq_status, 32'h0000_0001);
        rchk(addr_irq_status, 32'h0000_0002);
        chk({31'h0, irq}, 32'h0000_0001);
        wr(addr_irq_status, 32'h0000_0002);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0000_0000);
        wr(addr_irq_mask, 32'h0000_0000);
        i_host.apb(1'b0, 12'h03c, 32'h0000_0000, rv, er);
        chk(rv, 32'h0000_0000);
        chk({31'h0, er}, 32'h0000_0001);
        summarize();
    end
endmodule
`default_nettype wire
